// ==== src/i2c_core_regs.svh ====
`ifndef I2C_CORE_REGS_SVH
`define I2C_CORE_REGS_SVH
// reset values and fixed codes of the core
`define PRESCALE_RST      8'h00
`define SCL_DIV_RST       16'h0008
`define TEN_BIT_PREFIX    5'h1E
`define FILTER_LEN        3
`define SYNC_STAGES       2
`define WORD_LEN_FULL     4'h8
`define DIV_MIN           16'h0001
`endif

// ==== src/i2c_core_pkg.sv ====
package i2c_core_pkg;
  // control word from software
  typedef struct packed {
    logic       master_select;        // act as master
    logic       start_request;        // request start or repeated start
    logic       stop_request;         // request stop
    logic       ten_bit_addr_enable;  // 10-bit address format
    logic       free_format_enable;   // data only, no address
    logic       readDir;              // direction bit: 1 = master reads
    logic [2:0] word_bit_count;       // 0 selects 8 bits
  } ctrl_type;
  // status bits back to software
  typedef struct packed {
    logic bus_busy_flag;              // start seen, no stop yet
    logic arbLost;                    // lost arbitration
    logic masterActive;               // we own the bus
    logic nackSeen;                   // last ack slot read high
  } status_type;
  // open-drain pin, oe low while driving low
  typedef struct packed {
    logic out;                        // always 0 when driven
    logic oe_n;                       // 0 = pull low
  } od_pin_type;
endpackage

// ==== src/i2c_glitch_filter.sv ====
`include "i2c_core_regs.svh"
// resynchronises one bus line and removes short pulses
module i2c_glitch_filter #(
  parameter int STAGES = `SYNC_STAGES,  // synchroniser depth
  parameter int LEN    = `FILTER_LEN    // samples that must agree
) (
  input  wire logic clk,                // system clock
  input  wire logic sys_rst,            // async reset, high
  input  wire logic lineIn,             // raw pin level
  output logic      lineOut             // clean level
);
  logic [STAGES-1:0] sync_q;            // synchroniser chain
  logic [LEN-1:0]    hist_q;            // filter history
  logic              out_q;             // filtered level

  // chain idles high like the bus
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_q <= '1;
      hist_q <= '1;
      out_q  <= 1'b1;
    end else begin
      sync_q <= {sync_q[STAGES-2:0], lineIn};
      hist_q <= {hist_q[LEN-2:0], sync_q[STAGES-1]};
      // only the last stage feeds the filter, stage one is never gated
      if (&hist_q) begin
        out_q <= 1'b1;
      end else if (~|hist_q) begin
        out_q <= 1'b0;
      end
    end
  end
  assign lineOut = out_q;
endmodule

// ==== src/i2c_bus_controller_core.sv ====
`include "i2c_core_regs.svh"
// Behaviour
// - no high-speed; 10-bit always sends both bytes
// - tx word copied to shifter, shifted out
// - rx shifter copied to rx data word
// - SCL high and low from separate dividers
// - prescaler taken only when reset bit rises
// - SCL fall restarts low; high waits release
// - stretched SCL low makes generator wait
// - pins only pulled low or released
// - SDA changes only while SCL low
// - start and stop made with SCL high
// - busy set on start, cleared on stop
// - start needs master and start request
// - stop only after stop request
// - start while we are active master gives repeated start
// - word 1 to 8 bits, 0 means 8
// - one SCL pulse per bit, MSB first
// - any number of words per transfer
// - arbitration against other masters
// - both inputs noise filtered
// - DMA events for receive and transmit
// - 7-bit address then direction bit
// - 10-bit prefix 11110, two bits, write
// - free format sends data straight after start
module i2c_bus_controller_core
  import i2c_core_pkg::*;
#(
  parameter int PW = 8,                            // prescaler width
  parameter int DW = 16                            // divider width
) (
  input  wire logic                   clk,         // 100 MHz clock
  input  wire logic                   sys_rst,     // async reset, high
  input  wire logic                   module_reset_n, // low holds core
  input  wire logic [PW-1:0]          prescale_reg,   // divide minus one
  input  wire logic [DW-1:0]          scl_high_div_reg, // high length
  input  wire logic [DW-1:0]          scl_low_div_reg,  // low length
  input  wire i2c_core_pkg::ctrl_type ctrl,        // control bits
  input  wire logic [9:0]             slaveAddr,   // target address
  input  wire logic [7:0]             tx_data_reg, // word to send
  input  wire logic                   txLoad,      // tx_data_reg written
  input  wire logic                   rxTaken,     // rx word read
  input  wire logic                   sdaIn,       // SDA pin level
  input  wire logic                   sclIn,       // SCL pin level
  output i2c_core_pkg::od_pin_type    sdaPin,      // SDA drive
  output i2c_core_pkg::od_pin_type    sclPin,      // SCL drive
  output logic [7:0]                  rx_data_reg, // last word received
  output i2c_core_pkg::status_type    status,      // status flags
  output logic                        txDmaReq,    // pulse: tx word wanted
  output logic                        rxDmaReq     // pulse: rx word ready
);
  import i2c_core_pkg::*;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,   // bus released
    ST_START = 7'h02,   // SDA falls while SCL high
    ST_LOW   = 7'h04,   // SCL low, set SDA
    ST_HIGH  = 7'h08,   // SCL high, sample
    ST_WAIT  = 7'h10,   // released, held low by someone
    ST_STOP  = 7'h20,   // SDA rises while SCL high
    ST_RSTRT = 7'h40    // release SDA before repeated start
  } state_type;

  // phase of the byte stream
  typedef enum logic [3:0] {
    PH_ADDR1 = 4'h1,    // first address byte
    PH_ADDR2 = 4'h2,    // second 10-bit byte
    PH_DATA  = 4'h4,    // data words
    PH_ACK   = 4'h8     // unused code kept one-hot
  } phase_type;

  state_type        state_q, state_d;              // bit engine state
  phase_type        phase_q;                       // stream phase
  logic [PW-1:0]    psc_q;                         // latched prescaler
  logic [PW-1:0]    pcnt_q;                        // prescale counter
  logic             tick;                          // module clock tick
  logic             rstBitQ;                       // delayed reset bit
  logic [DW-1:0]    dcnt_q;                        // phase counter
  logic [7:0]       txShift_q;                     // tx_shift_reg
  logic [7:0]       rxShift_q;                     // rx_shift_reg
  logic [3:0]       bitCnt_q;                      // bits left incl ack
  logic             ackSlot;                       // current bit is ack
  logic             sdaOe_n_q, sclOe_n_q;          // pin drive regs
  logic             sdaF, sclF, sdaF_q, sclF_q;    // filtered lines
  logic             busy_q, lost_q, act_q, nack_q; // status regs
  logic             txReq_q, rxReq_q;              // dma pulses
  logic [7:0]       rxData_q;                      // rx word reg
  logic             isRead_q;                      // master receiving
  logic [3:0]       wordLen;                       // decoded length
  logic             startSeen, stopSeen, sclFall;  // bus events
  logic             divDone;                       // phase time over
  logic             wantStart;                     // start gating

  // bit count 0 means a full byte
  function automatic logic [3:0] word_len(input logic [2:0] bc);
    word_len = (bc == 3'h0) ? `WORD_LEN_FULL : {1'b0, bc};
  endfunction

  // inputs resynchronised then filtered
  i2c_glitch_filter u_sda (
    .clk     (clk),
    .sys_rst (sys_rst),
    .lineIn  (sdaIn),
    .lineOut (sdaF)
  );
  i2c_glitch_filter u_scl (
    .clk     (clk),
    .sys_rst (sys_rst),
    .lineIn  (sclIn),
    .lineOut (sclF)
  );

  assign wordLen   = word_len(ctrl.word_bit_count);
  assign startSeen = sclF & sclF_q & sdaF_q & ~sdaF;
  assign stopSeen  = sclF & sclF_q & ~sdaF_q & sdaF;
  assign sclFall   = sclF_q & ~sclF;
  assign tick      = (pcnt_q == '0);
  assign divDone   = tick & (dcnt_q <= `DIV_MIN);
  assign ackSlot   = (bitCnt_q == 4'h1);
  assign wantStart = ctrl.master_select & ctrl.start_request;

  // prescaler value only taken as the reset bit rises
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rstBitQ <= 1'b0;
      psc_q   <= `PRESCALE_RST;
      pcnt_q  <= '0;
    end else begin
      rstBitQ <= module_reset_n;
      if (module_reset_n & ~rstBitQ) begin
        psc_q <= prescale_reg;
      end
      // module clock tick divides the input clock
      pcnt_q <= (pcnt_q == '0 || !module_reset_n) ? psc_q : pcnt_q - 1'b1;
    end
  end

  // filtered line history and bus busy
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sdaF_q <= 1'b1;
      sclF_q <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      sdaF_q <= sdaF;
      sclF_q <= sclF;
      if (!module_reset_n) begin
        busy_q <= 1'b0;
      end else if (startSeen) begin
        busy_q <= 1'b1;
      end else if (stopSeen) begin
        busy_q <= 1'b0;
      end
    end
  end

  // next state of the bit engine
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        // only a free bus gets a fresh start
        if (wantStart && !busy_q) begin
          state_d = ST_START;
        end
      end
      ST_START: begin
        if (divDone) begin
          state_d = ST_LOW;
        end
      end
      ST_LOW: begin
        // low timed from the fall
        if (divDone) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // clock released but held by a slower party
        if (sclF) begin
          state_d = ST_HIGH;
        end
      end
      ST_HIGH: begin
        // another master pulled SCL early
        if (sclFall) begin
          state_d = ST_LOW;
        end else if (divDone) begin
          state_d = ST_LOW;
        end
      end
      ST_STOP: begin
        // done only once SCL is ours released and seen high
        if (divDone && sclF && sclOe_n_q) begin
          state_d = ST_IDLE;
        end
      end
      ST_RSTRT: begin
        if (divDone && sclF) begin
          state_d = ST_START;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (!module_reset_n || lost_q) begin
      state_d = ST_IDLE;
    end
  end

  // bit engine registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q   <= ST_IDLE;
      phase_q   <= PH_ADDR1;
      dcnt_q    <= `SCL_DIV_RST;
      txShift_q <= '0;
      rxShift_q <= '0;
      bitCnt_q  <= 4'h9;
      sdaOe_n_q <= 1'b1;
      sclOe_n_q <= 1'b1;
      lost_q    <= 1'b0;
      act_q     <= 1'b0;
      nack_q    <= 1'b0;
      isRead_q  <= 1'b0;
      txReq_q   <= 1'b0;
      rxReq_q   <= 1'b0;
      rxData_q  <= '0;
    end else begin
      state_q <= state_d;
      txReq_q <= 1'b0;
      rxReq_q <= 1'b0;
      if (tick) begin
        dcnt_q <= (dcnt_q > `DIV_MIN) ? dcnt_q - 1'b1 : dcnt_q;
      end
      if (!module_reset_n) begin
        sdaOe_n_q <= 1'b1;
        sclOe_n_q <= 1'b1;
        act_q     <= 1'b0;
        lost_q    <= 1'b0;
      end else begin
        if (lost_q && !busy_q) begin
          lost_q <= 1'b0;
        end
        case (state_q)
          ST_IDLE: begin
            sdaOe_n_q <= 1'b1;
            sclOe_n_q <= 1'b1;
            act_q     <= 1'b0;
            if (state_d == ST_START) begin
              dcnt_q <= scl_high_div_reg;
            end
          end
          ST_START: begin
            // SDA pulled while SCL high
            sdaOe_n_q <= 1'b0;
            act_q     <= 1'b1;
            if (state_d == ST_LOW) begin
              sclOe_n_q <= 1'b0;
              dcnt_q    <= scl_low_div_reg;
              phase_q   <= ctrl.free_format_enable ? PH_DATA : PH_ADDR1;
              isRead_q  <= ctrl.free_format_enable & ctrl.readDir;
              bitCnt_q  <= ctrl.free_format_enable ? wordLen + 4'h1 : 4'h9;
              // address byte or first data word
              if (ctrl.free_format_enable) begin
                txShift_q <= tx_data_reg << (4'h8 - wordLen);
                txReq_q   <= 1'b1;
              end else if (ctrl.ten_bit_addr_enable) begin
                txShift_q <= {`TEN_BIT_PREFIX, slaveAddr[9:8], 1'b0};
              end else begin
                txShift_q <= {slaveAddr[6:0], ctrl.readDir};
              end
            end
          end
          ST_LOW: begin
            // data driven only while SCL low
            sclOe_n_q <= 1'b0;
            if (bitCnt_q == 4'h0) begin
              // word done: stop, repeated start or next word
              if (ctrl.stop_request) begin
                sdaOe_n_q <= 1'b0;
              end else if (wantStart) begin
                sdaOe_n_q <= 1'b1;
              end
            end else if (ackSlot) begin
              sdaOe_n_q <= ~(isRead_q & ~ctrl.stop_request);
            end else begin
              sdaOe_n_q <= isRead_q | txShift_q[7];
            end
            if (state_d == ST_WAIT) begin
              sclOe_n_q <= 1'b1;
              dcnt_q    <= scl_high_div_reg;
            end
          end
          ST_WAIT: begin
            dcnt_q <= scl_high_div_reg;
          end
          ST_HIGH: begin
            // sample on the first tick of the high phase and check arbitration
            if (dcnt_q == scl_high_div_reg && tick && bitCnt_q != 4'h0) begin
              if (!ackSlot) begin
                rxShift_q <= {rxShift_q[6:0], sdaF};
                txShift_q <= {txShift_q[6:0], 1'b0};
                if (!isRead_q && sdaOe_n_q && !sdaF) begin
                  lost_q <= 1'b1;
                end
              end else begin
                nack_q <= sdaF;
              end
              bitCnt_q <= bitCnt_q - 4'h1;
            end
            if (state_d == ST_LOW) begin
              sclOe_n_q <= 1'b0;
              dcnt_q    <= scl_low_div_reg;
              if (bitCnt_q == 4'h0) begin
                // last read word is kept even when a stop follows
                if (phase_q == PH_DATA && isRead_q) begin
                  rxData_q <= rxShift_q & (8'hFF >> (4'h8 - wordLen));
                  rxReq_q  <= 1'b1;
                end
                if (ctrl.stop_request) begin
                  // SDA pulled with SCL going low so it can rise later
                  state_q   <= ST_STOP;
                  dcnt_q    <= scl_low_div_reg;
                  sdaOe_n_q <= 1'b0;
                end else if (wantStart) begin
                  state_q <= ST_RSTRT;
                  dcnt_q  <= scl_high_div_reg;
                end else begin
                  // next word, unlimited count
                  bitCnt_q <= wordLen + 4'h1;
                  if (phase_q == PH_ADDR1 && ctrl.ten_bit_addr_enable) begin
                    phase_q   <= PH_ADDR2;
                    bitCnt_q  <= 4'h9;
                    txShift_q <= slaveAddr[7:0];
                  end else begin
                    if (phase_q == PH_ADDR1) begin
                      isRead_q <= ctrl.readDir;
                    end
                    phase_q   <= PH_DATA;
                    txShift_q <= tx_data_reg << (4'h8 - wordLen);
                    txReq_q   <= 1'b1;
                  end
                end
              end
            end
          end
          ST_STOP: begin
            // low phase first, then SCL released, then SDA
            if (!sclOe_n_q && divDone) begin
              sclOe_n_q <= 1'b1;
              dcnt_q    <= scl_high_div_reg;
            end
            if (sclOe_n_q && sclF && divDone) begin
              sdaOe_n_q <= 1'b1;
            end
          end
          ST_RSTRT: begin
            sdaOe_n_q <= 1'b1;
            sclOe_n_q <= 1'b1;
            if (state_d == ST_START) begin
              dcnt_q <= scl_high_div_reg;
            end
          end
          default: begin
            sdaOe_n_q <= 1'b1;
          end
        endcase
      end
    end
  end

  // outputs straight from flip-flops
  assign sdaPin      = '{out: 1'b0, oe_n: sdaOe_n_q};
  assign sclPin      = '{out: 1'b0, oe_n: sclOe_n_q};
  assign rx_data_reg = rxData_q;
  assign status      = '{bus_busy_flag: busy_q, arbLost: lost_q,
                         masterActive: act_q, nackSeen: nack_q};
  assign txDmaReq    = txReq_q;
  assign rxDmaReq    = rxReq_q;

  // busy flag follows start condition next cycle
  a_busy_on_start: assert property (@(posedge clk) disable iff (sys_rst)
    module_reset_n && startSeen |=> busy_q)
    else $error("busy not set after start");
  // stop clears busy
  a_busy_off_stop: assert property (@(posedge clk) disable iff (sys_rst)
    module_reset_n && stopSeen && !startSeen |=> !busy_q)
    else $error("busy not cleared after stop");
  // prescaler frozen while running
  a_psc_frozen: assert property (@(posedge clk) disable iff (sys_rst)
    rstBitQ && module_reset_n |=> $stable(psc_q))
    else $error("prescaler changed while running");
  // no start attempt without master select
  a_start_gated: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == ST_IDLE && !ctrl.master_select |=> state_q != ST_START)
    else $error("start without master select");
  // SDA drive changes only while SCL is held low in data
  a_sda_stable: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == ST_HIGH && $past(state_q) == ST_HIGH |-> $stable(sdaOe_n_q))
    else $error("SDA changed while SCL high");
  // start pulls SDA with SCL released
  a_start_shape: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == ST_START && $past(state_q) == ST_START |-> sclOe_n_q)
    else $error("SCL driven during start");
  // waiting holds SCL released until the line rises
  a_wait_release: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == ST_WAIT && !sclF |=> sclOe_n_q && state_q != ST_HIGH)
    else $error("high timed while SCL held low");
  // tx dma pulse lasts one cycle
  a_dma_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    txDmaReq |=> !txDmaReq)
    else $error("tx dma request longer than a cycle");
endmodule

// ==== sim/i2c_slave_model.sv ====
// bus target: acks, serves reads, may stretch clock
module i2c_slave_model (
  input  wire logic       clk,      // sample clock
  input  wire logic       sda,      // resolved data line
  input  wire logic       scl,      // resolved clock line
  input  wire logic [3:0] wordLen,  // data word bits
  input  wire logic [1:0] hdrWords, // address bytes
  input  wire logic [7:0] rdData,   // word served on reads
  input  wire logic [7:0] stretch,  // extra low cycles
  output logic            sdaDrvN,  // low pulls data
  output logic            sclDrvN,  // low pulls clock
  output int              wordCnt,  // words since start
  output int              startCnt, // starts seen
  output int              stopCnt   // stops seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];      // words taken in
  logic [7:0] sh;          // incoming bits
  logic       sdaQ = 1'b1; // last data level
  logic       sclQ = 1'b1; // last clock level
  logic       rdMode;      // we send data words
  logic       tx;          // sending this word
  int         bitCnt, hold, n;
  initial begin
    sdaDrvN = 1'b1;
    sclDrvN = 1'b1;
    {wordCnt, startCnt, stopCnt, bitCnt, hold} = '0;
    rdMode = 1'b0;
  end
  // sampled off the edge so the design never races us
  always @(posedge clk) begin
    #1;
    n = (wordCnt < hdrWords) ? 8 : wordLen;
    tx = rdMode && wordCnt >= hdrWords;
    if (hold > 0) hold--;
    else sclDrvN = 1'b1;
    if (sclQ && scl && sdaQ && !sda) begin
      startCnt++;
      {bitCnt, wordCnt} = '0;
      rdMode = 1'b0;
      sdaDrvN = 1'b1;
    end else if (sclQ && scl && !sdaQ && sda) begin
      stopCnt++;
    end else if (!sclQ && scl) begin
      if (bitCnt < n) sh = {sh[6:0], sda};
      else if (tx && sda) rdMode = 1'b0;   // nack ends our words
      bitCnt++;
    end else if (sclQ && !scl) begin
      if (bitCnt == n) got.push_back(sh & (8'hFF >> (8 - n)));
      if (bitCnt == n + 1) begin
        if (wordCnt == 0 && hdrWords == 1)
          rdMode = got[got.size()-1][0];
        bitCnt = 0;
        wordCnt++;
        hold = stretch;
        sclDrvN = (stretch == 8'h00);
        n = (wordCnt < hdrWords) ? 8 : wordLen;
      end
      tx = rdMode && wordCnt >= hdrWords;
      // change data only while clock is low
      if (tx && bitCnt < n) sdaDrvN = rdData[n-1-bitCnt];
      else sdaDrvN = !(bitCnt == n && !tx);
    end
    sdaQ = sda;
    sclQ = scl;
  end
endmodule

// ==== sim/test_i2c_bus_controller_core.sv ====
module test_i2c_bus_controller_core;
  import i2c_core_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, sys_rst = 1, module_reset_n = 0;
  logic        txLoad = 0, rxTaken = 0, txDmaReq, rxDmaReq;
  logic [7:0]  prescale_reg = 8'h0D, tx_data_reg = 8'hC3, rx_data_reg;
  logic [7:0]  stretch = 8'h00;
  logic [15:0] sclHi = 16'h0005, sclLo = 16'h0008;
  logic [9:0]  slaveAddr = 10'h05A;
  logic [3:0]  wordLen = 4'h8;
  logic [1:0]  hdrWords = 2'h1;
  ctrl_type    ctrl = '0;
  od_pin_type  sdaPin, sclPin;
  status_type  status;
  logic        sdaDrvN, sclDrvN;
  int wordCnt, startCnt, stopCnt, errors = 0, checked = 0, s, p;
  int hiRun = 0, loRun = 0, hiMax, loMax, txCnt, rxCnt;
  // pull-ups make the wired-AND
  wire sda = sdaPin.oe_n & sdaDrvN;
  wire scl = sclPin.oe_n & sclDrvN;
  i2c_bus_controller_core i2c_bus_controller_core_i (.clk(clk),
    .sys_rst(sys_rst), .module_reset_n(module_reset_n),
    .prescale_reg(prescale_reg), .scl_high_div_reg(sclHi),
    .scl_low_div_reg(sclLo), .ctrl(ctrl), .slaveAddr(slaveAddr),
    .tx_data_reg(tx_data_reg), .txLoad(txLoad), .rxTaken(rxTaken),
    .sdaIn(sda), .sclIn(scl), .sdaPin(sdaPin), .sclPin(sclPin),
    .rx_data_reg(rx_data_reg), .status(status), .txDmaReq(txDmaReq),
    .rxDmaReq(rxDmaReq));
  i2c_slave_model i2c_slave_model_i (.clk(clk), .sda(sda), .scl(scl),
    .wordLen(wordLen), .hdrWords(hdrWords), .rdData(8'hA5),
    .stretch(stretch), .sdaDrvN(sdaDrvN), .sclDrvN(sclDrvN),
    .wordCnt(wordCnt), .startCnt(startCnt), .stopCnt(stopCnt));
  always #5 clk = ~clk;
  // longest clock high and low runs once the first word is done
  always @(posedge clk) begin
    txCnt <= txCnt + txDmaReq;
    rxCnt <= rxCnt + rxDmaReq;
    hiRun <= scl ? hiRun + 1 : 0;
    loRun <= scl ? 0 : loRun + 1;
    if (wordCnt > 0 && !scl && hiRun > hiMax) hiMax <= hiRun;
    if (wordCnt > 0 && scl && loRun > loMax) loMax <= loRun;
  end
  task automatic check(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      errors++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  task automatic report_and_stop;
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic waitBusy(input logic v);
    for (int i = 0; i < 40000 && status.bus_busy_flag !== v; i++)
      @(posedge clk);
    #1;
    check(status.bus_busy_flag === v, "busy wait");
  endtask
  task automatic waitWord(input int w);
    for (int i = 0; i < 40000 && wordCnt != w; i++) @(posedge clk);
    @(posedge clk);
    #1;
  endtask
  // one transfer: start, header, optional first word then restart and header again, nw words, stop
  task automatic xfer(input logic [2:0] bc, input logic ten, fr, rd,
                      input int nw, input logic rs);
    int h;
    h = fr ? 0 : (ten ? 2 : 1);
    i2c_slave_model_i.got.delete();
    {hiMax, loMax, txCnt, rxCnt} = '0;
    hdrWords = h[1:0];
    wordLen = (bc == 3'h0) ? 4'h8 : {1'b0, bc};
    ctrl = {1'b1, 1'b1, 1'b0, ten, fr, rd, bc};
    s = startCnt;
    txLoad = 1'b1;
    rxTaken = 1'b1;
    waitBusy(1'b1);
    ctrl.start_request = 1'b0;
    txLoad = 1'b0;
    rxTaken = 1'b0;
    if (rs) begin
      waitWord(h);
      ctrl.start_request = 1'b1;
      for (int i = 0; i < 40000 && startCnt < s + 2; i++) @(posedge clk);
      #1;
      ctrl.start_request = 1'b0;
    end
    waitWord(h + nw - 1);
    ctrl.stop_request = 1'b1;
    waitBusy(1'b0);
    ctrl.stop_request = 1'b0;
  endtask
  initial begin
    #1000000;
    errors++;
    report_and_stop;
  end
  initial begin
    repeat (6) @(posedge clk);
    #1 sys_rst = 1'b0;
    check(sdaPin.oe_n === 1'b1 && sclPin.oe_n === 1'b1, "idle");
    check(status === '0 && rx_data_reg === 8'h00, "reset");
    module_reset_n = 1'b1;
    ctrl.start_request = 1'b1;
    repeat (300) @(posedge clk);
    #1;
    check(startCnt === 0 && sdaPin.oe_n === 1'b1, "no master");
    xfer(3'h0, 1'b0, 1'b0, 1'b0, 2, 1'b0);
    check(i2c_slave_model_i.got[0] === 8'hB4, "address");
    check(i2c_slave_model_i.got[2] === 8'hC3, "words");
    check(i2c_slave_model_i.got[1] === 8'hC3, "word");
    check(stopCnt === 1 && status.bus_busy_flag === 1'b0, "stop");
    check(hiMax >= 64 && hiMax <= 92, "high time");
    check(loMax >= 100 && loMax <= 134, "low time");
    check(txCnt > 0, "tx event");
    check(status.arbLost === 1'b0 && status.masterActive === 1'b0 &&
          status.nackSeen === 1'b0, "status after write");
    check(sdaPin.out === 1'b0 && sclPin.out === 1'b0, "drive");
    prescale_reg = 8'h08;
    xfer(3'h0, 1'b0, 1'b0, 1'b0, 1, 1'b0);
    check(hiMax >= 64, "prescale held");
    module_reset_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 module_reset_n = 1'b1;
    repeat (2) @(posedge clk);
    #1 xfer(3'h0, 1'b0, 1'b0, 1'b0, 1, 1'b0);
    check(hiMax >= 40 && hiMax <= 63, "prescale taken");
    check(loMax >= 64 && loMax <= 90, "new low");
    stretch = 8'hC8;
    xfer(3'h3, 1'b0, 1'b0, 1'b1, 1, 1'b0);
    check(i2c_slave_model_i.got[0] === 8'hB5, "read address");
    check(rx_data_reg === 8'h05, "read word");
    check(rxCnt > 0 && loMax >= 200, "rx event");
    check(status.nackSeen === 1'b1, "last read nacked");
    stretch = 8'h00;
    slaveAddr = 10'h2A7;
    xfer(3'h0, 1'b1, 1'b0, 1'b0, 1, 1'b0);
    check(i2c_slave_model_i.got[0] === 8'hF4, "ten bit");
    check(i2c_slave_model_i.got[1] === 8'hA7, "low byte");
    tx_data_reg = 8'h13;
    xfer(3'h5, 1'b0, 1'b1, 1'b0, 1, 1'b0);
    check(i2c_slave_model_i.got[0] === 8'h13, "free");
    slaveAddr = 10'h05A;
    p = stopCnt;
    xfer(3'h0, 1'b0, 1'b0, 1'b0, 1, 1'b1);
    check(startCnt === s + 2 && stopCnt === p + 1, "restart");
    report_and_stop;
  end
endmodule
